//--- hdl/ccp_pkg.sv
// Shared constants and carrier types for the port control register bank
package ccp_pkg;

   // Register offsets
   localparam logic [7:0] CCP_ADR_TOGGLE = 8'h04;
   localparam logic [7:0] CCP_ADR_ATTACH = 8'h05;
   localparam logic [7:0] CCP_ADR_MANUAL = 8'h09;
   localparam logic [7:0] CCP_ADR_SRST   = 8'h0A;
   localparam logic [7:0] CCP_ADR_GATE_A = 8'h0E;
   localparam logic [7:0] CCP_ADR_GATE_B = 8'h0F;

   // Values after reset
   localparam logic [7:0] CCP_RST_TOGGLE = 8'h4B;
   localparam logic [7:0] CCP_RST_ATTACH = 8'hB3;
   localparam logic [7:0] CCP_RST_MANUAL = 8'h00;
   localparam logic [7:0] CCP_RST_GATE   = 8'h00;

   // Implemented bits of the gate registers; reserved bits read zero
   localparam logic [7:0] CCP_GATE_A_BITS = 8'h7F;
   localparam logic [7:0] CCP_GATE_B_BITS = 8'h6F;

   // Manual command bit positions
   localparam int CCP_MAN_SRC  = 5;
   localparam int CCP_MAN_SNK  = 4;
   localparam int CCP_MAN_USNK = 3;
   localparam int CCP_MAN_USRC = 2;
   localparam int CCP_MAN_DIS  = 1;
   localparam int CCP_MAN_ERR  = 0;
   localparam int CCP_SRST_BIT = 0;

   // Timing: clock rate, toggle cycle and debounce figures in ms
   localparam int unsigned CCP_CLK_HZ     = 25000000;
   localparam int unsigned CCP_MS_CYCLES  = CCP_CLK_HZ / 1000;
   localparam logic [7:0]  CCP_TOG_BASE_MS = 8'h3C;
   localparam logic [7:0]  CCP_DEB_BASE_MS = 8'h78;
   localparam logic [7:0]  CCP_STEP_MS     = 8'h0A;
   localparam logic [7:0]  CCP_SINK_PCT0   = 8'h3C;
   localparam logic [7:0]  CCP_PCT_STEP    = 8'h0A;
   localparam logic [7:0]  CCP_PCT_FULL    = 8'h64;
   localparam logic [2:0]  CCP_DEB_MAX_SEL = 3'h6;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccp_req_t;

   typedef struct packed {
      logic [1:0] toggle_cycle_length;
      logic [1:0] toggle_duty_split;
      logic       dangling_cable_fix_on;
      logic [1:0] source_pullup_level;
      logic       remedy_on;
      logic [1:0] weak_battery_level;
      logic       weak_battery_role_on;
   } ccp_cfg_t;

   typedef enum logic [6:0] {
      CCP_CMD_NONE = 7'h01,
      CCP_CMD_DIS  = 7'h02,
      CCP_CMD_ERR  = 7'h04,
      CCP_CMD_SRC  = 7'h08,
      CCP_CMD_SNK  = 7'h10,
      CCP_CMD_USRC = 7'h20,
      CCP_CMD_USNK = 7'h40
   } ccp_cmd_t;

endpackage : ccp_pkg

//--- hdl/ccp_port_ctrl.sv
// Control register bank of the autonomous connector port controller
//
// Contract
// - Toggle cycle length code selects 60, 70, 80 or 90 ms total.
// - Duty code splits cycle sink/source as 60/40, 50/50, 40/60, 30/70.
// - Dangling cable enable turns on the stabilisation methods.
// - Pull-up code selects 80, 180 or 330 uA; code 00 never written.
// - Global mask set keeps the interrupt pin released for all sources.
// - Remedy enable turns on remedy detection.
// - Weak battery threshold code selects 3.0 to 3.3 V.
// - Auto sink enable switches to sink when supply below threshold.
// - Register mode runs only with enable bit set and enable pin low.
// - Attach debounce is 120 ms plus 10 ms per step; 111 unused.
// - Role command bits are write-one and clear themselves after acting.
// - Force commands make the port behave as source or sink.
// - Idle commands move the port into idle sink or source state.
// - Fault restart command moves the port into error recovery.
// - Disable bit is plain read/write and holds the port disabled.
// - Several commands at once: only the highest priority one acts.
// - All lower priority commands written with it are cleared.
// - Disable blocks role settings; role settings beat other commands.
// - Soft restart resets logic and registers; the bit self-clears.
// - First gate register bits stop matching flags reaching the pin.
// - Second gate register bits stop matching flags reaching the pin.
// - Masked flags still set; pin releases when no unmasked flag pends.
`timescale 1ns/1ps
module ccp_port_ctrl
   import ccp_pkg::*;
#(
   parameter int unsigned MS_CYCLES = CCP_MS_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire ccp_req_t   reg_req,
   input  wire logic       en_n,
   input  wire logic       pin_mode,
   input  wire logic       supply_below,
   input  wire logic       attach_raw,
   input  wire logic       portrole_change,
   input  wire logic [7:0] flags_a,
   input  wire logic [7:0] flags_b,
   output logic [7:0]      rd_data_r,
   output logic            rd_valid_r,
   output ccp_cfg_t        cfg_r,
   output logic            operational_r,
   output logic            auto_sink_r,
   output logic            drp_sink_phase_r,
   output logic            attach_stable_r,
   output ccp_cmd_t        role_cmd_r,
   output logic            role_disabled_r,
   output logic            portrole_apply_r,
   output logic            soft_restart_r,
   output logic            int_n_r
);

   logic       gmask_r;
   logic       sw_enable_r;
   logic [2:0] attach_debounce_sel_r;
   logic [7:0] gate_a_r;
   logic [7:0] gate_b_r;
   logic [7:0] wc_r;
   logic [31:0] pre_r;
   logic       ms_tick;
   logic [7:0] phase_ms_r;
   logic [7:0] deb_ms_r;
   logic [7:0] tog_total_ms;
   logic [7:0] sink_ms;
   logic [7:0] deb_len_ms;
   logic [15:0] sink_prod;
   logic       rst_all;
   logic       wr;
   logic [7:0] wsel;
   logic [7:0] rd_nxt;
   ccp_cmd_t   cmd_nxt;

   assign wr      = reg_req.valid && reg_req.write;
   // Soft restart reaches every register except the read path and its own bit one edge after its write
   assign rst_all = !rstn || soft_restart_r;

   // Soft restart bit never reads back as one: its address is not in the read path; it lives one cycle only
   always_ff @(posedge clk) begin
      if (!rstn) begin
         soft_restart_r <= 1'b0;
      end else begin
         soft_restart_r <= wr && reg_req.addr == CCP_ADR_SRST
                           && reg_req.wdata[CCP_SRST_BIT];
      end
   end

   // Toggle and current control register
   always_ff @(posedge clk) begin
      if (rst_all) begin
         cfg_r.toggle_cycle_length   <= CCP_RST_TOGGLE[7:6];
         cfg_r.toggle_duty_split     <= CCP_RST_TOGGLE[5:4];
         cfg_r.dangling_cable_fix_on <= CCP_RST_TOGGLE[3];
         cfg_r.source_pullup_level   <= CCP_RST_TOGGLE[2:1];
         gmask_r                     <= CCP_RST_TOGGLE[0];
      end else if (wr && reg_req.addr == CCP_ADR_TOGGLE) begin
         cfg_r.toggle_cycle_length   <= reg_req.wdata[7:6];
         cfg_r.toggle_duty_split     <= reg_req.wdata[5:4];
         cfg_r.dangling_cable_fix_on <= reg_req.wdata[3];
         // Reserved pull-up code is stored as written; host keeps it out
         cfg_r.source_pullup_level   <= reg_req.wdata[2:1];
         gmask_r                     <= reg_req.wdata[0];
      end
   end

   // Attach behaviour control register
   always_ff @(posedge clk) begin
      if (rst_all) begin
         cfg_r.remedy_on            <= CCP_RST_ATTACH[7];
         cfg_r.weak_battery_level   <= CCP_RST_ATTACH[6:5];
         cfg_r.weak_battery_role_on <= CCP_RST_ATTACH[4];
         sw_enable_r                <= CCP_RST_ATTACH[3];
         attach_debounce_sel_r      <= CCP_RST_ATTACH[2:0];
      end else if (wr && reg_req.addr == CCP_ADR_ATTACH) begin
         cfg_r.remedy_on            <= reg_req.wdata[7];
         cfg_r.weak_battery_level   <= reg_req.wdata[6:5];
         cfg_r.weak_battery_role_on <= reg_req.wdata[4];
         sw_enable_r                <= reg_req.wdata[3];
         attach_debounce_sel_r      <= reg_req.wdata[2:0];
      end
   end

   // Gate registers; only implemented bits are stored
   always_ff @(posedge clk) begin
      if (rst_all) begin
         gate_a_r <= CCP_RST_GATE;
         gate_b_r <= CCP_RST_GATE;
      end else if (wr) begin
         if (reg_req.addr == CCP_ADR_GATE_A) begin
            gate_a_r <= reg_req.wdata & CCP_GATE_A_BITS;
         end
         if (reg_req.addr == CCP_ADR_GATE_B) begin
            gate_b_r <= reg_req.wdata & CCP_GATE_B_BITS;
         end
      end
   end

   // Priority pick of one written command; the rest are dropped at once
   always_comb begin
      wsel = 8'h00;
      if (reg_req.wdata[CCP_MAN_DIS]) begin
         wsel[CCP_MAN_DIS] = 1'b1;
      end else if (reg_req.wdata[CCP_MAN_ERR]) begin
         wsel[CCP_MAN_ERR] = 1'b1;
      end else if (reg_req.wdata[CCP_MAN_SRC]) begin
         wsel[CCP_MAN_SRC] = 1'b1;
      end else if (reg_req.wdata[CCP_MAN_SNK]) begin
         wsel[CCP_MAN_SNK] = 1'b1;
      end else if (reg_req.wdata[CCP_MAN_USRC]) begin
         wsel[CCP_MAN_USRC] = 1'b1;
      end else if (reg_req.wdata[CCP_MAN_USNK]) begin
         wsel[CCP_MAN_USNK] = 1'b1;
      end
   end

   always_comb begin
      cmd_nxt = CCP_CMD_NONE;
      if (wc_r[CCP_MAN_ERR]) begin
         cmd_nxt = CCP_CMD_ERR;
      end else if (wc_r[CCP_MAN_SRC]) begin
         cmd_nxt = CCP_CMD_SRC;
      end else if (wc_r[CCP_MAN_SNK]) begin
         cmd_nxt = CCP_CMD_SNK;
      end else if (wc_r[CCP_MAN_USRC]) begin
         cmd_nxt = CCP_CMD_USRC;
      end else if (wc_r[CCP_MAN_USNK]) begin
         cmd_nxt = CCP_CMD_USNK;
      end
   end

   // Disable bit: plain storage, only the host clears it
   always_ff @(posedge clk) begin
      if (rst_all) begin
         role_disabled_r <= CCP_RST_MANUAL[CCP_MAN_DIS];
      end else if (wr && reg_req.addr == CCP_ADR_MANUAL) begin
         role_disabled_r <= wsel[CCP_MAN_DIS];
      end
   end

   // Self-clearing commands: held one cycle, then issued and cleared.
   // A write landing on the issue cycle becomes the next pending command; the old one still issues.
   always_ff @(posedge clk) begin
      if (rst_all) begin
         wc_r <= CCP_RST_MANUAL;
      end else if (wr && reg_req.addr == CCP_ADR_MANUAL) begin
         wc_r <= {wsel[7:2], 1'b0, wsel[0]};
      end else begin
         wc_r <= 8'h00;
      end
   end

   // A role setting change discards pending commands unless disabled
   always_ff @(posedge clk) begin
      if (rst_all) begin
         role_cmd_r <= CCP_CMD_NONE;
      end else if (portrole_change && !role_disabled_r) begin
         role_cmd_r <= CCP_CMD_NONE;
      end else begin
         role_cmd_r <= cmd_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst_all) begin
         portrole_apply_r <= 1'b0;
      end else begin
         portrole_apply_r <= portrole_change && !role_disabled_r;
      end
   end

   // Enable: pin mode needs only the pin, register mode needs both
   always_ff @(posedge clk) begin
      if (rst_all) begin
         operational_r <= 1'b0;
      end else begin
         operational_r <= !en_n && (pin_mode || sw_enable_r);
      end
   end

   always_ff @(posedge clk) begin
      if (rst_all) begin
         auto_sink_r <= 1'b0;
      end else begin
         auto_sink_r <= operational_r && cfg_r.weak_battery_role_on
                        && supply_below;
      end
   end

   // Millisecond prescaler shared by toggle and debounce timing
   assign ms_tick = pre_r == MS_CYCLES - 1;

   always_ff @(posedge clk) begin
      if (rst_all || ms_tick) begin
         pre_r <= 32'h0000_0000;
      end else begin
         pre_r <= pre_r + 32'h0000_0001;
      end
   end

   // Every split of every length is a whole number of ms
   assign tog_total_ms = CCP_TOG_BASE_MS
                         + CCP_STEP_MS * {6'h00, cfg_r.toggle_cycle_length};
   assign sink_prod    = 16'(tog_total_ms) * 16'(CCP_SINK_PCT0
                         - CCP_PCT_STEP * {6'h00, cfg_r.toggle_duty_split});
   assign sink_ms      = 8'(sink_prod / 16'(CCP_PCT_FULL));

   always_ff @(posedge clk) begin
      if (rst_all || !operational_r) begin
         phase_ms_r <= 8'h00;
      end else if (phase_ms_r >= tog_total_ms) begin
         // Shortened cycle: restart at once rather than overrun
         phase_ms_r <= 8'h00;
      end else if (ms_tick) begin
         if (phase_ms_r >= tog_total_ms - 8'h01) begin
            phase_ms_r <= 8'h00;
         end else begin
            phase_ms_r <= phase_ms_r + 8'h01;
         end
      end
   end

   // Sink share comes first in each cycle, source share follows
   always_ff @(posedge clk) begin
      if (rst_all) begin
         drp_sink_phase_r <= 1'b1;
      end else begin
         drp_sink_phase_r <= phase_ms_r < sink_ms;
      end
   end

   // Reserved debounce code is clamped to the longest legal time
   assign deb_len_ms = CCP_DEB_BASE_MS + CCP_STEP_MS * {5'h00,
      (attach_debounce_sel_r > CCP_DEB_MAX_SEL) ? CCP_DEB_MAX_SEL
                                                : attach_debounce_sel_r};

   always_ff @(posedge clk) begin
      if (rst_all || !attach_raw || !operational_r) begin
         deb_ms_r <= 8'h00;
      end else if (ms_tick && deb_ms_r < deb_len_ms) begin
         deb_ms_r <= deb_ms_r + 8'h01;
      end
   end

   // A drop of the raw attach ends the stable indication immediately
   always_ff @(posedge clk) begin
      if (rst_all) begin
         attach_stable_r <= 1'b0;
      end else begin
         attach_stable_r <= attach_raw && deb_ms_r >= deb_len_ms;
      end
   end

   // Masks gate only the pin; the flag bank keeps its own bits
   always_ff @(posedge clk) begin
      if (rst_all) begin
         int_n_r <= 1'b1;
      end else begin
         int_n_r <= gmask_r
            || !(|(flags_a & ~gate_a_r & CCP_GATE_A_BITS)
                 || |(flags_b & ~gate_b_r & CCP_GATE_B_BITS));
      end
   end

   // Read path; unmapped and reserved locations read zero
   always_comb begin
      case (reg_req.addr)
         CCP_ADR_TOGGLE: rd_nxt = {cfg_r.toggle_cycle_length,
                                   cfg_r.toggle_duty_split,
                                   cfg_r.dangling_cable_fix_on,
                                   cfg_r.source_pullup_level, gmask_r};
         CCP_ADR_ATTACH: rd_nxt = {cfg_r.remedy_on,
                                   cfg_r.weak_battery_level,
                                   cfg_r.weak_battery_role_on,
                                   sw_enable_r, attach_debounce_sel_r};
         CCP_ADR_MANUAL: rd_nxt = wc_r | {6'h00, role_disabled_r, 1'b0};
         CCP_ADR_GATE_A: rd_nxt = gate_a_r;
         CCP_ADR_GATE_B: rd_nxt = gate_b_r;
         default:        rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_data_r  <= 8'h00;
         rd_valid_r <= 1'b0;
      end else begin
         rd_data_r  <= (reg_req.valid && !reg_req.write) ? rd_nxt : 8'h00;
         rd_valid_r <= reg_req.valid && !reg_req.write;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_toggle_bound;
      $stable(cfg_r.toggle_cycle_length) |-> phase_ms_r < tog_total_ms;
   endproperty
   a_toggle_bound: assert property (p_toggle_bound)
      else $error("toggle phase beyond cycle length");

   property p_sink_share;
      !soft_restart_r
         |=> drp_sink_phase_r == ($past(phase_ms_r) < $past(sink_ms));
   endproperty
   a_sink_share: assert property (p_sink_share)
      else $error("sink phase does not follow duty split");

   property p_gmask_quiet;
      gmask_r && !soft_restart_r |=> int_n_r;
   endproperty
   a_gmask_quiet: assert property (p_gmask_quiet)
      else $error("interrupt pin asserted under global mask");

   property p_unmasked_pin;
      !gmask_r && !soft_restart_r
         && |(flags_a & ~gate_a_r & CCP_GATE_A_BITS) |=> !int_n_r;
   endproperty
   a_unmasked_pin: assert property (p_unmasked_pin)
      else $error("unmasked flag did not assert interrupt pin");

   property p_masked_release;
      !soft_restart_r && !(|(flags_a & ~gate_a_r & CCP_GATE_A_BITS))
         && !(|(flags_b & ~gate_b_r & CCP_GATE_B_BITS)) |=> int_n_r;
   endproperty
   a_masked_release: assert property (p_masked_release)
      else $error("interrupt pin held by masked flags only");

   property p_enable_pin;
      en_n |=> !operational_r;
   endproperty
   a_enable_pin: assert property (p_enable_pin)
      else $error("operational while enable pin high");

   property p_cmd_become_provider;
      wr && reg_req.addr == CCP_ADR_MANUAL && reg_req.wdata == 8'h20
         && !soft_restart_r
         ##1 !(wr && reg_req.addr == CCP_ADR_MANUAL) && !portrole_change
         && !soft_restart_r |=> role_cmd_r == CCP_CMD_SRC;
   endproperty
   a_cmd_become_provider: assert property (p_cmd_become_provider)
      else $error("force source command not issued");

   property p_disable_wins;
      wr && reg_req.addr == CCP_ADR_MANUAL && reg_req.wdata[CCP_MAN_DIS]
         && !soft_restart_r |=> role_disabled_r && wc_r == 8'h00;
   endproperty
   a_disable_wins: assert property (p_disable_wins)
      else $error("disable did not override other commands");

   property p_self_clear;
      role_cmd_r != CCP_CMD_NONE
         && !$past(wr && reg_req.addr == CCP_ADR_MANUAL) |-> wc_r == 8'h00;
   endproperty
   a_self_clear: assert property (p_self_clear)
      else $error("command bits not cleared after acting");

   property p_disable_blocks;
      role_disabled_r && portrole_change && !soft_restart_r
         |=> !portrole_apply_r;
   endproperty
   a_disable_blocks: assert property (p_disable_blocks)
      else $error("role setting applied while disabled");

   property p_soft_restart;
      wr && reg_req.addr == CCP_ADR_SRST && reg_req.wdata[CCP_SRST_BIT]
         |=> ##1 gate_a_r == CCP_RST_GATE && !soft_restart_r
         && sw_enable_r == CCP_RST_ATTACH[3];
   endproperty
   a_soft_restart: assert property (p_soft_restart)
      else $error("soft restart did not restore registers");

   property p_debounce;
      attach_stable_r |-> $past(deb_ms_r) >= $past(deb_len_ms);
   endproperty
   a_debounce: assert property (p_debounce)
      else $error("attach reported before debounce time");

endmodule : ccp_port_ctrl

//--- verification/ccp_host_model.sv
// Host processor model that drives the register request port
`timescale 1ns/1ps
module ccp_host_model
   import ccp_pkg::*;
(
   input  wire logic       clk,
   output ccp_req_t        req,
   input  wire logic [7:0] rd_data_r,
   input  wire logic       rd_valid_r
);
   initial req = '{1'b0, 1'b0, 8'h00, 8'h00};

   // One access per call. Idle lines carry inverted values so that a stale
   // address or data can never pass for a fresh request.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] s, output logic [7:0] q,
                      output logic v);
      s = d;
      if (w && a == CCP_ADR_TOGGLE && s[2:1] == 2'h0) s[2:1] = 2'h1;
      if (w && a == CCP_ADR_ATTACH && s[2:0] == 3'h7) s[2:0] = 3'h6;
      @(negedge clk);
      req <= '{1'b1, w, a, s};
      @(negedge clk);
      q = rd_data_r;
      v = rd_valid_r;
      req <= '{1'b0, w, ~a, ~s};
   endtask : acc
endmodule : ccp_host_model

//--- verification/tb_ccp_port_ctrl.sv
// Self-checking bench for the port control register bank
`timescale 1ns/1ps
module tb_ccp_port_ctrl
   import ccp_pkg::*;
;
   localparam int MSC = 4;
   logic       clk, rstn, en_n, pin_mode, supply_below, attach_raw;
   logic       portrole_change, rd_valid_r, operational_r, auto_sink_r;
   logic       drp_sink_phase_r, attach_stable_r, role_disabled_r;
   logic       portrole_apply_r, soft_restart_r, int_n_r;
   logic [7:0] flags_a, flags_b, rd_data_r, v;
   ccp_req_t   reg_req;
   ccp_cfg_t   cfg_r;
   ccp_cmd_t   role_cmd_r;
   int         n_mismatch, cmp_count, seed, n, i;
   int         mir [16];
   int         km [16] = '{0, 0, 0, 0, 8'hFF, 8'hFF, 0, 0, 0, 8'h02, 0, 0,
                           0, 0, CCP_GATE_A_BITS, CCP_GATE_B_BITS};
   int         adr [9] = '{0, 3, 4, 5, 9, 10, 14, 15, 16};

   ccp_host_model i_host (.clk(clk), .req(reg_req), .rd_data_r(rd_data_r),
                          .rd_valid_r(rd_valid_r));

   ccp_port_ctrl #(.MS_CYCLES(MSC)) i_dut (
      .clk(clk), .rstn(rstn), .reg_req(reg_req), .en_n(en_n),
      .pin_mode(pin_mode), .supply_below(supply_below),
      .attach_raw(attach_raw), .portrole_change(portrole_change),
      .flags_a(flags_a), .flags_b(flags_b), .rd_data_r(rd_data_r),
      .rd_valid_r(rd_valid_r), .cfg_r(cfg_r), .operational_r(operational_r),
      .auto_sink_r(auto_sink_r), .drp_sink_phase_r(drp_sink_phase_r),
      .attach_stable_r(attach_stable_r), .role_cmd_r(role_cmd_r),
      .role_disabled_r(role_disabled_r),
      .portrole_apply_r(portrole_apply_r),
      .soft_restart_r(soft_restart_r), .int_n_r(int_n_r));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic wrap_up();
      if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up

   // Hang guard, well beyond the few thousand cycles the run needs
   initial begin
      #2000000;
      n_mismatch++;
      wrap_up();
   end

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic near(input int a, input int b);
      return a >= b - MSC && a <= b + MSC + 2;
   endfunction : near

   function automatic ccp_cmd_t pick(input logic [7:0] c);
      if (c[0]) return CCP_CMD_ERR;
      if (c[5]) return CCP_CMD_SRC;
      if (c[4]) return CCP_CMD_SNK;
      if (c[2]) return CCP_CMD_USRC;
      if (c[3]) return CCP_CMD_USNK;
      return CCP_CMD_NONE;
   endfunction : pick

   task automatic mreset();
      mir = '{default: 0};
      mir[4] = CCP_RST_TOGGLE;
      mir[5] = CCP_RST_ATTACH;
   endtask : mreset

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] s, q;
      logic       vv;
      i_host.acc(1'b1, a, d, s, q, vv);
      if (a < 16) mir[a] = s & km[a];
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic [7:0] s, q;
      logic       vv;
      i_host.acc(1'b0, a, 8'h00, s, q, vv);
      chk("rd_valid", vv, 1);
      chk("rd_data", q, (a < 16) ? mir[a] : 0);
   endtask : rd

   task automatic cfg_chk();
      chk("cycle", cfg_r.toggle_cycle_length, (mir[4] >> 6) & 3);
      chk("duty", cfg_r.toggle_duty_split, (mir[4] >> 4) & 3);
      chk("dangle", cfg_r.dangling_cable_fix_on, (mir[4] >> 3) & 1);
      chk("pullup", cfg_r.source_pullup_level, (mir[4] >> 1) & 3);
      chk("remedy", cfg_r.remedy_on, (mir[5] >> 7) & 1);
      chk("wb_lvl", cfg_r.weak_battery_level, (mir[5] >> 5) & 3);
      chk("wb_on", cfg_r.weak_battery_role_on, (mir[5] >> 4) & 1);
   endtask : cfg_chk

   task automatic tog(input int c, input int d);
      int hi, lo;
      wr(CCP_ADR_TOGGLE, 8'((c << 6) | (d << 4) | 8'h0A));
      n = 0;
      while (drp_sink_phase_r !== 1'b0 && n < 900) begin
         @(negedge clk);
         n++;
      end
      while (drp_sink_phase_r !== 1'b1 && n < 900) begin
         @(negedge clk);
         n++;
      end
      hi = 0;
      lo = 0;
      while (drp_sink_phase_r === 1'b1 && hi < 900) begin
         @(negedge clk);
         hi++;
      end
      while (drp_sink_phase_r === 1'b0 && lo < 900) begin
         @(negedge clk);
         lo++;
      end
      chk("cycle_len", near(hi + lo, (60 + 10 * c) * MSC), 1);
      chk("sink_len",
          near(hi, (60 + 10 * c) * (60 - 10 * d) * MSC / 100), 1);
   endtask : tog

   task automatic role_try(input logic expv);
      logic seen;
      seen = 1'b0;
      portrole_change = 1'b1;
      repeat (4) begin
         @(negedge clk);
         portrole_change = 1'b0;
         seen = seen | portrole_apply_r;
      end
      chk("apply", seen, expv);
   endtask : role_try

   initial begin
      seed = 32'h625D6FC8;
      n_mismatch = 0;
      cmp_count = 0;
      {rstn, en_n, pin_mode, supply_below, attach_raw} = 5'b01000;
      portrole_change = 1'b0;
      flags_a = 8'h00;
      flags_b = 8'h00;
      mreset();
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      chk("int_n", int_n_r, 1);
      chk("cmd", role_cmd_r, CCP_CMD_NONE);
      foreach (adr[k]) rd(8'(adr[k]));
      for (i = 0; i < 6; i++) begin
         wr(CCP_ADR_TOGGLE, 8'($random(seed)));
         wr(CCP_ADR_ATTACH, 8'($random(seed)));
         cfg_chk();
         rd(CCP_ADR_TOGGLE);
         rd(CCP_ADR_ATTACH);
      end
      for (i = 0; i < 8; i++) begin
         en_n = i[0];
         pin_mode = i[1];
         wr(CCP_ADR_ATTACH, 8'h06 | (8'(i[2]) << 3));
         repeat (3) @(negedge clk);
         chk("oper", operational_r, !i[0] && (i[1] || i[2]));
      end
      en_n = 1'b0;
      for (i = 0; i < 4; i++) begin
         wr(CCP_ADR_ATTACH, 8'h0E | 8'(i[0] << 4));
         supply_below = i[1];
         repeat (3) @(negedge clk);
         chk("auto_sink", auto_sink_r, i[0] & i[1]);
      end
      supply_below = 1'b0;
      for (i = 0; i < 4; i++) tog(i, i);
      for (i = 0; i < 7; i += 6) begin
         wr(CCP_ADR_ATTACH, 8'h08 | 8'(i));
         attach_raw = 1'b1;
         n = 0;
         while (attach_stable_r !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
         end
         chk("debounce", near(n, (120 + 10 * i) * MSC), 1);
         attach_raw = 1'b0;
         repeat (3) @(negedge clk);
      end
      for (i = 0; i < 16; i++) begin
         v = (i < 5) ? 8'(1 << (i + (i > 0))) : 8'($random(seed)) & 8'h3D;
         wr(CCP_ADR_MANUAL, v);
         portrole_change = i[3] & i[0];
         @(negedge clk);
         portrole_change = 1'b0;
         chk("cmd", role_cmd_r, (i[3] & i[0]) ? CCP_CMD_NONE : pick(v));
         @(negedge clk);
         chk("cmd_end", role_cmd_r, CCP_CMD_NONE);
         rd(CCP_ADR_MANUAL);
      end
      for (i = 0; i < 24; i++) begin
         wr(CCP_ADR_GATE_A, 8'($random(seed)));
         wr(CCP_ADR_GATE_B, 8'($random(seed)));
         wr(CCP_ADR_TOGGLE, 8'h4A | 8'(i[2] & i[0]));
         flags_a = 8'($random(seed)) & CCP_GATE_A_BITS;
         flags_b = 8'($random(seed)) & CCP_GATE_B_BITS;
         // Host acknowledges a random set of flags_a bits; the bench clears them directly
         if (i[1]) flags_a = flags_a & ~8'($random(seed));
         repeat (2) @(negedge clk);
         chk("int_n", int_n_r, mir[4][0] | !(|(flags_a & ~8'(mir[14]))
             || |(flags_b & ~8'(mir[15]))));
         rd(CCP_ADR_GATE_A);
         rd(CCP_ADR_GATE_B);
      end
      wr(CCP_ADR_MANUAL, 8'h3F);
      @(negedge clk);
      chk("dis_only", role_cmd_r, CCP_CMD_NONE);
      chk("disabled", role_disabled_r, 1);
      rd(CCP_ADR_MANUAL);
      role_try(1'b0);
      wr(CCP_ADR_MANUAL, 8'h00);
      role_try(1'b1);
      wr(CCP_ADR_MANUAL, 8'h02);
      wr(CCP_ADR_GATE_A, 8'h55);
      wr(CCP_ADR_SRST, 8'h01);
      chk("srst", soft_restart_r, 1);
      mreset();
      repeat (2) @(negedge clk);
      chk("srst_end", soft_restart_r, 0);
      chk("disabled", role_disabled_r, 0);
      foreach (adr[k]) rd(8'(adr[k]));
      wrap_up();
   end
endmodule : tb_ccp_port_ctrl
